// ---- logic/pxe_map.vh ----
`ifndef PXE_MAP_VH
`define PXE_MAP_VH

// ==========================================================================
// address match
`define PXE_ADDR_UPPER    4'h4
`define PXE_GENERAL_CALL  7'h00

// ==========================================================================
// byte framing
`define PXE_BYTE_BITS     4'h8
`define PXE_LAST_TX_BIT   4'h7
`define PXE_BUF_WIDTH     9
`define PXE_HI_SEL_BIT    8

// ==========================================================================
// reset values
`define PXE_LATCH_RST     16'hFFFF
`define PXE_PULLUP_RST    16'h0000

`endif

// ---- logic/pxe_buf2.v ----
`timescale 1ns/1ps
`default_nettype none

`include "pxe_map.vh"

module pxe_buf2 #(
    parameter WIDTH = `PXE_BUF_WIDTH
) (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ======================================================================
    // storage
    reg [WIDTH-1:0] entry [0:1];
    reg             rd_ptr;
    reg             wr_ptr;
    reg [1:0]       count;

    wire            push;
    wire            pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = entry[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ======================================================================
    // pointers and count
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_ptr   <= 1'b0;
            wr_ptr   <= 1'b0;
            count    <= 2'h0;
            entry[0] <= {WIDTH{1'b0}};
            entry[1] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                entry[wr_ptr] <= in_data;
                wr_ptr        <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push & ~pop) begin
                count <= count + 2'h1;
            end else if (pop & ~push) begin
                count <= count - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- logic/pxe_expander.v ----
// What this block does
// (R01) sda falling while scl high is a start; address reception begins.
// (R02) address byte arrives msb first, direction bit last; shifted in that way.
// (R03) general call address is never acknowledged; sda stays released.
// (R04) matching address gets sda low through the ack clock high phase.
// (R05) system keeps the address straps steady from start to stop.
// (R06) address is 0100 then straps 2..0, giving 20h to 27h.
// (R07) direction high: transmit bytes of currently sampled port pin levels.
// (R08) direction low: master bytes become new port output values.
// (R09) a written data byte is acknowledged while the write buffer has room; nacked when it is full.
// (R10) ports change only after a whole byte is received and acknowledged.
// (R11) new output appears shortly after scl rises in the ack cycle.
// (R12) sda change while scl high is start or stop, never data.
// (R13) master ends with stop, sda rising while scl high; block goes idle.
// (R14) eight bits plus one ack per byte; byte count unlimited.
// (R15) byte sender releases sda before the ack clock.
// (R16) master acknowledges each read byte except the last.
// (R17) master nack ends a read; block releases sda for the stop.
// (R18) stop anywhere keeps last acknowledged outputs, drops untransferred input data.
// (R19) master starts only while the bus is idle.
// (R20) bytes alternate low port then high port; each pair overwrites the last.
// (R21) interrupt asserts on any edge of a port pin used as input.
// (R22) interrupt clears on pins restored or own read/write ack only.
// (R23) written high bit gets a strong pullup until next scl fall.
// (R24) address mismatch: sda released, all ignored until next start.
`timescale 1ns/1ps
`default_nettype none

`include "pxe_map.vh"

module pxe_expander (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // i2c pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    // address straps
    input  wire        addr_strap_0,
    input  wire        addr_strap_1,
    input  wire        addr_strap_2,
    // port pins
    input  wire [7:0]  port_lo_bits_in,
    input  wire [7:0]  port_hi_bits_in,
    output wire [7:0]  port_lo_bits_out,
    output reg  [7:0]  port_lo_bits_low_en,
    output reg  [7:0]  port_hi_bits_low_en,
    output reg  [7:0]  port_lo_bits_pullup,
    output reg  [7:0]  port_hi_bits_pullup,
    // latch update flow control
    input  wire        latch_ready,
    // interrupt pin, open drain
    output wire        int_n_out,
    output reg         int_n_oe
);

    // ======================================================================
    // states
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_ADDR     = 3'h1;
    localparam [2:0] ST_ADDR_ACK = 3'h2;
    localparam [2:0] ST_WR_DATA  = 3'h3;
    localparam [2:0] ST_WR_ACK   = 3'h4;
    localparam [2:0] ST_RD_DATA  = 3'h5;
    localparam [2:0] ST_RD_ACK   = 3'h6;
    localparam [2:0] ST_IGNORE   = 3'h7;

    // open drain pins only ever pull low
    assign sda_out          = 1'b0;
    assign int_n_out        = 1'b0;
    assign port_lo_bits_out = 8'h00;

    // ======================================================================
    // pin synchronisers
    // a bit counts as changed only once stages two and three agree,
    // which also filters single-sample glitches on the slow pins
    localparam NSYNC = 21;

    wire [NSYNC-1:0] raw_pins;
    reg  [NSYNC-1:0] sync1;
    reg  [NSYNC-1:0] sync2;
    reg  [NSYNC-1:0] sync3;
    reg  [NSYNC-1:0] filt;

    assign raw_pins = {port_hi_bits_in, port_lo_bits_in,
                       addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl_in};

    always @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= {NSYNC{1'b1}};
            sync2 <= {NSYNC{1'b1}};
            sync3 <= {NSYNC{1'b1}};
            filt  <= {NSYNC{1'b1}};
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
        end
    end

    wire        scl_f   = filt[0];
    wire        sda_f   = filt[1];
    wire [2:0]  straps  = filt[4:2];
    wire [15:0] pins    = filt[20:5];

    // ======================================================================
    // bus event detection
    reg scl_q;
    reg sda_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    wire scl_rise   = scl_f & ~scl_q;
    wire scl_fall   = ~scl_f & scl_q;
    wire start_cond = scl_f & scl_q & sda_q & ~sda_f;   // see (R01)
    wire stop_cond  = scl_f & scl_q & ~sda_q & sda_f;   // see (R13)

    // ======================================================================
    // address decode
    function addr_match;
        input [6:0] addr;
        input [2:0] strap;
        begin
            addr_match = (addr != `PXE_GENERAL_CALL) &&          // see (R03)
                         (addr == {`PXE_ADDR_UPPER, strap});     // see (R06)
        end
    endfunction

    // ======================================================================
    // write buffer toward the port latches
    reg        push_valid;
    reg  [8:0] push_data;
    wire       buf_in_ready;
    wire       buf_out_valid;
    wire [8:0] buf_out_data;

    pxe_buf2 #(
        .WIDTH     (`PXE_BUF_WIDTH)
    ) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_valid),
        .in_ready  (buf_in_ready),
        .in_data   (push_data),
        .out_valid (buf_out_valid),
        .out_ready (latch_ready),
        .out_data  (buf_out_data)
    );

    // ======================================================================
    // protocol engine
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg       hi_sel;
    reg       master_ack;
    reg       ref_load;

    always @(posedge clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            hi_sel     <= 1'b0;
            master_ack <= 1'b0;
            sda_oe     <= 1'b0;
            push_valid <= 1'b0;
            push_data  <= 9'h000;
            ref_load   <= 1'b0;
        end else begin
            push_valid <= 1'b0;
            ref_load   <= 1'b0;
            if (start_cond) begin
                state   <= ST_ADDR;                             // see (R01)
                bit_cnt <= 4'h0;
                hi_sel  <= 1'b0;
                sda_oe  <= 1'b0;
            end else if (stop_cond) begin
                // pending read data is dropped, latches keep their value
                state  <= ST_IDLE;                              // see (R13)
                sda_oe <= 1'b0;                                 // see (R18)
            end else begin
                case (state)
                ST_ADDR, ST_WR_DATA: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_f};         // see (R02)
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `PXE_BYTE_BITS) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (addr_match(shreg[7:1], straps)) begin
                                sda_oe     <= 1'b1;             // see (R04)
                                master_ack <= shreg[0];
                                state      <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IGNORE;             // see (R24)
                            end
                        end else if (buf_in_ready) begin
                            sda_oe <= 1'b1;                     // see (R09)
                            state  <= ST_WR_ACK;
                        end else begin
                            // no room: nack rather than lose a byte
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    // master_ack holds the direction bit here
                    if (scl_rise && master_ack) begin
                        ref_load <= 1'b1;                       // see (R22)
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (master_ack) begin
                            shreg  <= pins[7:0];                // see (R07)
                            sda_oe <= ~pins[7];
                            state  <= ST_RD_DATA;
                        end else begin
                            sda_oe   <= 1'b0;                   // see (R08)
                            ref_load <= 1'b1;                   // see (R22)
                            state    <= ST_WR_DATA;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_rise) begin
                        push_valid <= 1'b1;                     // see (R10)
                        push_data  <= {hi_sel, shreg};          // see (R11)
                        hi_sel     <= ~hi_sel;                  // see (R20)
                    end else if (scl_fall) begin
                        sda_oe   <= 1'b0;                       // see (R14)
                        ref_load <= 1'b1;                       // see (R22)
                        state    <= ST_WR_DATA;
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == `PXE_LAST_TX_BIT) begin
                            sda_oe <= 1'b0;                     // see (R15)
                            state  <= ST_RD_ACK;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            shreg   <= {shreg[6:0], 1'b0};
                            sda_oe  <= ~shreg[6];               // see (R12)
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda_f;                   // see (R16)
                        ref_load   <= 1'b1;                     // see (R22)
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (master_ack) begin
                            shreg  <= hi_sel ? pins[7:0] : pins[15:8];
                            sda_oe <= hi_sel ? ~pins[7] : ~pins[15];
                            hi_sel <= ~hi_sel;                  // see (R20)
                            state  <= ST_RD_DATA;
                        end else begin
                            state <= ST_IGNORE;                 // see (R17)
                        end
                    end
                end
                default: begin
                    // idle and ignore wait for the next start
                    sda_oe <= 1'b0;                             // see (R24)
                end
                endcase
            end
        end
    end

    // ======================================================================
    // port latches and strong pullups
    wire       pop      = buf_out_valid & latch_ready;
    wire [7:0] pop_byte = buf_out_data[7:0];
    wire       pop_hi   = buf_out_data[`PXE_HI_SEL_BIT];
    localparam [15:0] LATCH_RST  = `PXE_LATCH_RST;
    localparam [15:0] PULLUP_RST = `PXE_PULLUP_RST;

    always @(posedge clk) begin
        if (sys_rst) begin
            port_lo_bits_low_en <= ~LATCH_RST[7:0];
            port_hi_bits_low_en <= ~LATCH_RST[15:8];
            port_lo_bits_pullup <= PULLUP_RST[7:0];
            port_hi_bits_pullup <= PULLUP_RST[15:8];
        end else begin
            if (scl_fall) begin
                port_lo_bits_pullup <= 8'h00;                   // see (R23)
                port_hi_bits_pullup <= 8'h00;
            end
            // a new high wins over the clearing fall in the same cycle
            if (pop && !pop_hi) begin
                port_lo_bits_low_en <= ~pop_byte;               // see (R20)
                port_lo_bits_pullup <= pop_byte;                // see (R23)
            end
            if (pop && pop_hi) begin
                port_hi_bits_low_en <= ~pop_byte;               // see (R20)
                port_hi_bits_pullup <= pop_byte;                // see (R23)
            end
        end
    end

    // ======================================================================
    // input change interrupt
    // pins driven low are outputs and never raise the interrupt;
    // a change landing on the ack pulse itself may be swallowed
    reg  [15:0] ref_pins;
    wire [15:0] in_mode = ~{port_hi_bits_low_en, port_lo_bits_low_en};

    always @(posedge clk) begin
        if (sys_rst) begin
            ref_pins <= `PXE_LATCH_RST;
            int_n_oe <= 1'b0;
        end else begin
            if (ref_load) begin
                ref_pins <= pins;                               // see (R22)
            end
            int_n_oe <= |((pins ^ ref_pins) & in_mode);         // see (R21)
        end
    end

endmodule

`default_nettype wire

// ---- dv/pxe_expander_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module pxe_expander_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // i2c pins
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // port pins
    input wire logic [7:0] port_lo_bits_in,
    input wire logic [7:0] port_hi_bits_in,
    input wire logic [7:0] port_lo_bits_low_en,
    input wire logic [7:0] port_hi_bits_low_en,
    input wire logic [7:0] port_lo_bits_pullup,
    input wire logic [7:0] port_hi_bits_pullup,
    // interrupt
    input wire logic       int_n_out,
    input wire logic       int_n_oe
);
    // ==========
    // pin activity age, saturating
    logic [15:0] pins_q;
    logic [3:0]  quiet;
    always_ff @(posedge clk) begin
        pins_q <= {port_hi_bits_in, port_lo_bits_in};
        if (sys_rst) begin
            // reset reloads an all-high reference, so low pins count as fresh
            quiet <= 4'h0;
        end else if ({port_hi_bits_in, port_lo_bits_in} != pins_q) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========
    // assertions
    data_odrain_a: assert property (sda_out == 1'b0)
        else $error("sda_out not zero");
    int_odrain_a: assert property (int_n_out == 1'b0)
        else $error("int_n_out not zero");
    ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("sda pull too short");
    oe_scl_low_a: assert property (!$stable(sda_oe) |-> !scl_in)
        else $error("sda changed with scl high");
    port_upd_a: assert property (!$stable({port_hi_bits_low_en, port_lo_bits_low_en}) |-> scl_in)
        else $error("port changed outside ack high");
    pullup_high_a: assert property (((port_lo_bits_pullup & port_lo_bits_low_en) == 8'h00)
        && ((port_hi_bits_pullup & port_hi_bits_low_en) == 8'h00)) else $error("pullup on low bit");
    pullup_off_a: assert property ((!scl_in) [*8] |-> {port_hi_bits_pullup, port_lo_bits_pullup} == 16'h0000)
        else $error("pullup kept after scl fall");
    int_cause_a: assert property ($rose(int_n_oe) |-> quiet < 4'hC)
        else $error("interrupt without pin edge");

    cover property ($rose(sda_oe));
    cover property ($rose(int_n_oe));
    cover property ($rose(port_lo_bits_pullup[0]));
endmodule

bind pxe_expander pxe_expander_chk u_chk (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .port_lo_bits_in(port_lo_bits_in), .port_hi_bits_in(port_hi_bits_in),
    .port_lo_bits_low_en(port_lo_bits_low_en), .port_hi_bits_low_en(port_hi_bits_low_en),
    .port_lo_bits_pullup(port_lo_bits_pullup), .port_hi_bits_pullup(port_hi_bits_pullup),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe));

`default_nettype wire

// ---- dv/pxe_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module pxe_master (
    // bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // scl stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ==========
    // bus cycles
    task bit_cyc(input logic low, output logic s);
        sda_low = low;
        #40 scl = 1'b1;
        #40 s = sda;
        #40 scl = 1'b0;
        #40;
    endtask
    task start;
        sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask
    task stop;
        sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask
    task xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ak);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_cyc(~d[i], q[i]);
        end
        bit_cyc(mack, ak);
    endtask
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ==========
    // signals
    logic        clk, sys_rst, latch_ready, ak, a0;
    logic [2:0]  strap;
    logic [7:0]  ext_lo, ext_hi, q;
    logic [15:0] exp_en;
    logic [26:0] rows [0:10];
    int          fail_count, comparisons, cycles, i;
    wire         scl, sda_low, sda_oe, sda, int_n_oe;
    wire  [7:0]  lo_en, hi_en, lo_in, hi_in;
    // pulled-up wires
    assign sda = ~(sda_oe | sda_low);
    assign lo_in = ext_lo & ~lo_en;
    assign hi_in = ext_hi & ~hi_en;

    pxe_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    pxe_expander uut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .port_lo_bits_in(lo_in), .port_hi_bits_in(hi_in), .port_lo_bits_out(),
        .port_lo_bits_low_en(lo_en), .port_hi_bits_low_en(hi_en), .port_lo_bits_pullup(),
        .port_hi_bits_pullup(), .latch_ready(latch_ready), .int_n_out(), .int_n_oe(int_n_oe));

    // ==========
    // tasks
    task chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("fails %0d compares %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task wr(input logic [6:0] a, input logic [7:0] l, input logic [7:0] h);
        m.start;
        m.xfer({a, 1'b0}, 1'b0, q, a0);
        m.xfer(l, 1'b0, q, ak);
        m.xfer(h, 1'b0, q, ak);
        m.stop;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            report_and_stop;
        end
    end

    // ==========
    // main sequence
    initial begin
        sys_rst = 1'b1;
        latch_ready = 1'b1;
        strap = 3'h0;
        ext_lo = 8'hFF;
        ext_hi = 8'hFF;
        exp_en = 16'h0000;
        for (i = 0; i < 8; i++) begin
            rows[i] = {i[2:0], 7'h20 + 7'(i), 8'hA0 | 8'(i), 8'h0F ^ 8'(i << 4), 1'b0};
        end
        rows[8] = {3'h3, 7'h20, 8'h00, 8'h00, 1'b1};
        rows[9] = {3'h0, 7'h00, 8'h00, 8'h00, 1'b1};
        rows[10] = {3'h0, 7'h28, 8'h00, 8'h00, 1'b1};
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        chk({hi_en, lo_en}, 16'h0000);
        chk({14'h0, sda_oe, int_n_oe}, 16'h0000);
        for (i = 0; i < 11; i++) begin
            strap = rows[i][26:24];
            repeat (8) @(negedge clk);
            wr(rows[i][23:17], rows[i][16:9], rows[i][8:1]);
            if (!rows[i][0]) exp_en = ~{rows[i][8:1], rows[i][16:9]};
            chk({15'h0, a0}, {15'h0, rows[i][0]});
            chk({hi_en, lo_en}, exp_en);
        end
        // stalled latch: third byte refused, first two kept
        latch_ready = 1'b0;
        m.start;
        m.xfer(8'h40, 1'b0, q, a0);
        m.xfer(8'h12, 1'b0, q, ak);
        m.xfer(8'h34, 1'b0, q, ak);
        m.xfer(8'h56, 1'b0, q, ak);
        chk({15'h0, ak}, 16'h0001);
        m.stop;
        chk({hi_en, lo_en}, exp_en);
        latch_ready = 1'b1;
        repeat (20) @(negedge clk);
        chk({hi_en, lo_en}, 16'hCBED);
        // odd byte count, then a torn byte
        m.start;
        m.xfer(8'h40, 1'b0, q, a0);
        m.xfer(8'hFF, 1'b0, q, ak);
        m.xfer(8'hFF, 1'b0, q, ak);
        m.xfer(8'h0F, 1'b0, q, ak);
        for (i = 0; i < 4; i++) m.bit_cyc(1'b1, ak);
        m.stop;
        chk({hi_en, lo_en}, 16'h00F0);
        // read of pin levels, high nibble of the low port held low
        ext_lo = 8'hA5;
        ext_hi = 8'h3C;
        repeat (8) @(negedge clk);
        m.start;
        m.xfer(8'h41, 1'b0, q, a0);
        chk({15'h0, a0}, 16'h0000);
        m.xfer(8'hFF, 1'b1, q, ak);
        chk({8'h00, q}, 16'h0005);
        m.xfer(8'hFF, 1'b0, q, ak);
        chk({8'h00, q}, 16'h003C);
        chk({15'h0, sda_oe}, 16'h0000);
        m.stop;
        // interrupt: foreign traffic keeps it, own read clears it
        ext_hi = 8'hC3;
        repeat (20) @(negedge clk);
        chk({15'h0, int_n_oe}, 16'h0001);
        wr(7'h27, 8'h00, 8'h00);
        chk({15'h0, int_n_oe}, 16'h0001);
        m.start;
        m.xfer(8'h41, 1'b0, q, a0);
        m.xfer(8'hFF, 1'b0, q, ak);
        m.stop;
        chk({15'h0, int_n_oe}, 16'h0000);
        // second reset in mid-run
        sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        chk({hi_en, lo_en}, 16'h0000);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
        chk({15'h0, sda_oe}, 16'h0000);
        report_and_stop;
    end
endmodule

`default_nettype wire
